// file: verilog/qdc_top.sv
`timescale 1ns/1ps
module qdc_top
  import qdc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_data_in_i,
  // Control pins
  input wire logic load_strobe_n_i,
  input wire logic hw_reset_n_i,
  input wire logic reset_level_select_i,
  // Converter codes
  output qdc_code_t [QDC_CHANNELS-1:0] dac_code_o,
  output qdc_code_t [QDC_CHANNELS-1:0] input_code_o,
  // Output stage control per channel
  output logic [7:0] pwrdn_mode_o,
  output logic [QDC_CHANNELS-1:0] amp_enable_o,
  output logic [QDC_CHANNELS-1:0] pull_1k_o,
  output logic [QDC_CHANNELS-1:0] pull_100k_o,
  // Status
  output logic [QDC_CHANNELS-1:0] load_mask_o,
  output logic por_busy_o,
  output logic hw_hold_o
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic qdc_code_t reset_code(input logic sel);
    qdc_code_t c;
    c = sel ? QDC_CODE_MID : QDC_CODE_ZERO;
    return c;
  endfunction

  function automatic logic [1:0] chan_mode(input logic [7:0] pd, input int ch);
    logic [1:0] m;
    m = pd[2*ch +: 2];
    return m;
  endfunction

  // ****************************************
  // Link side shifter
  // ****************************************
  qdc_frame_if frm_if ();

  qdc_shifter u_shifter (
    .sclk_i(sclk_i),
    .frame_sel_n_i(frame_sel_n_i),
    .serial_data_in_i(serial_data_in_i),
    .frm(frm_if.shifter)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; a level counts once stages two and three agree, which
  // filters a single metastable sample at the cost of one cycle of latency.
  logic [3:0] pin_raw;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] pin_r;
  logic [3:0] pin_d_r;

  assign pin_raw = {frame_sel_n_i, load_strobe_n_i, hw_reset_n_i, reset_level_select_i};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync1_r <= QDC_PIN_RESET;
      sync2_r <= QDC_PIN_RESET;
      sync3_r <= QDC_PIN_RESET;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_r <= QDC_PIN_RESET;
      pin_d_r <= QDC_PIN_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_r[i] <= sync3_r[i];
        end
      end
      pin_d_r <= pin_r;
    end
  end

  logic frame_rise;
  logic strobe_fall;
  logic strobe_low;
  logic hw_rst_low;
  logic level_sel;

  assign frame_rise = pin_r[QDC_PIN_FS] & ~pin_d_r[QDC_PIN_FS];
  assign strobe_fall = ~pin_r[QDC_PIN_LD] & pin_d_r[QDC_PIN_LD];
  assign strobe_low = ~pin_r[QDC_PIN_LD];
  assign hw_rst_low = ~pin_r[QDC_PIN_RS];
  assign level_sel = pin_r[QDC_PIN_SEL];

  // ****************************************
  // Frame capture
  // ****************************************
  // The link clock is halted while frame select is high, so the shifted
  // word is stable by the time the synchronised rise is seen here.
  logic [QDC_FRAME_W-1:0] frame_r;
  logic exec_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      frame_r <= '0;
      exec_r <= 1'b0;
    end else begin
      exec_r <= frame_rise;
      if (frame_rise) begin
        frame_r <= frm_if.word;
      end
    end
  end

  logic [3:0] cmd;
  logic [QDC_CHANNELS-1:0] chan_sel;
  qdc_code_t frame_data;

  assign cmd = frame_r[QDC_CMD_LSB +: 4];
  assign chan_sel = frame_r[QDC_ADDR_LSB +: QDC_CHANNELS];
  assign frame_data = frame_r[QDC_DATA_W-1:0];

  // ****************************************
  // Reset sequencer
  // ****************************************
  qdc_state_t state_r;
  logic [7:0] por_cnt_r;
  logic run;
  logic clearing;
  logic swrst_req;

  assign run = (state_r == QDC_ST_RUN) && !hw_rst_low;
  assign clearing = !run;
  assign swrst_req = run && exec_r && (cmd == QDC_CMD_SWRST);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= QDC_ST_POR;
      por_cnt_r <= QDC_POR_LOAD;
    end else begin
      case (state_r)
        QDC_ST_POR: begin
          // Strobe and hardware reset are not looked at here
          if (por_cnt_r <= 8'h01) begin
            state_r <= QDC_ST_RUN;
            por_cnt_r <= 8'h00;
          end else begin
            por_cnt_r <= por_cnt_r - 8'h01;
          end
        end
        QDC_ST_RUN: begin
          if (hw_rst_low) begin
            state_r <= QDC_ST_HOLD;
          end else if (swrst_req) begin
            state_r <= QDC_ST_POR;
            por_cnt_r <= QDC_POR_LOAD;
          end
        end
        QDC_ST_HOLD: begin
          if (!hw_rst_low) begin
            state_r <= QDC_ST_RUN;
          end
        end
        default: begin
          state_r <= QDC_ST_POR;
          por_cnt_r <= QDC_POR_LOAD;
        end
      endcase
    end
  end

  // ****************************************
  // Command strobes
  // ****************************************
  logic exec_run;
  logic do_wr_in;
  logic do_upd;
  logic do_wr_upd;
  logic do_pwrdn;
  logic do_mask;

  assign exec_run = run && exec_r;
  assign do_wr_in = exec_run && (cmd == QDC_CMD_WR_IN);
  assign do_upd = exec_run && (cmd == QDC_CMD_UPD);
  assign do_wr_upd = exec_run && (cmd == QDC_CMD_WR_UPD);
  assign do_pwrdn = exec_run && (cmd == QDC_CMD_PWRDN);
  assign do_mask = exec_run && (cmd == QDC_CMD_MASK);

  // ****************************************
  // Power-down modes
  // ****************************************
  logic [7:0] pd_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pd_r <= QDC_PD_RESET;
    end else if (clearing) begin
      pd_r <= QDC_PD_RESET;
    end else if (do_pwrdn) begin
      // Address nibble and middle byte play no part
      pd_r <= frame_r[7:0];
    end
  end

  // ****************************************
  // Load strobe mask
  // ****************************************
  logic [QDC_CHANNELS-1:0] mask_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_r <= QDC_MASK_RESET;
    end else if (clearing) begin
      mask_r <= QDC_MASK_RESET;
    end else if (do_mask) begin
      mask_r <= frame_r[QDC_CHANNELS-1:0];
    end
  end

  // ****************************************
  // Input registers
  // ****************************************
  // Writes go on regardless of the power-down field
  qdc_code_t [QDC_CHANNELS-1:0] input_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      input_r <= '0;
    end else begin
      for (int ch = 0; ch < QDC_CHANNELS; ch++) begin
        if (clearing) begin
          input_r[ch] <= reset_code(level_sel);
        end else if ((do_wr_in || do_wr_upd) && chan_sel[ch]) begin
          input_r[ch] <= frame_data;
        end
      end
    end
  end

  // ****************************************
  // DAC registers
  // ****************************************
  // A frame write wins over a strobe edge in the same cycle; the strobe
  // copy uses the input value from before that frame. Hosts keep the
  // strobe away from frame ends, so the collision is only a corner case.
  qdc_code_t [QDC_CHANNELS-1:0] dac_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dac_r <= '0;
    end else begin
      for (int ch = 0; ch < QDC_CHANNELS; ch++) begin
        if (clearing) begin
          dac_r[ch] <= reset_code(level_sel);
        end else if (chan_sel[ch] && (do_wr_upd || (do_wr_in && strobe_low))) begin
          // Strobe held low updates every addressed channel, mask or not
          dac_r[ch] <= frame_data;
        end else if (chan_sel[ch] && do_upd) begin
          dac_r[ch] <= input_r[ch];
        end else if (strobe_fall && !mask_r[ch]) begin
          // Masked channels see the strobe as high
          dac_r[ch] <= input_r[ch];
        end
      end
    end
  end

  // ****************************************
  // Output stage decode
  // ****************************************
  logic [QDC_CHANNELS-1:0] amp_en_r;
  logic [QDC_CHANNELS-1:0] p1k_r;
  logic [QDC_CHANNELS-1:0] p100k_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      amp_en_r <= '1;
      p1k_r <= '0;
      p100k_r <= '0;
    end else begin
      for (int ch = 0; ch < QDC_CHANNELS; ch++) begin
        amp_en_r[ch] <= chan_mode(pd_r, ch) == QDC_PD_NORMAL;
        p1k_r[ch] <= chan_mode(pd_r, ch) == QDC_PD_1K;
        p100k_r[ch] <= chan_mode(pd_r, ch) == QDC_PD_100K;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Three-state is neither amplifier nor pull-down; the code keeps its
  // value so that leaving power-down restores the programmed level.
  assign dac_code_o = dac_r;
  assign input_code_o = input_r;
  assign pwrdn_mode_o = pd_r;
  assign amp_enable_o = amp_en_r;
  assign pull_1k_o = p1k_r;
  assign pull_100k_o = p100k_r;
  assign load_mask_o = mask_r;
  assign por_busy_o = (state_r == QDC_ST_POR);
  assign hw_hold_o = (state_r == QDC_ST_HOLD);

endmodule

// file: verilog/qdc_pkg.sv
// Function
// - 24-bit frames, executed when frame select rises
// - Address nibble is a per-channel mask
// - Command 0100 applies low byte as power-down
// - Two mode bits per channel, D highest
// - Modes: normal, 1k, 100k, three-state
// - Power-down ignores address and middle byte
// - Power-down keeps registers, writes still work
// - 0001 with strobe low updates input and DAC
// - 0001 with strobe high updates input only
// - Strobe falling edge loads unmasked DAC registers
// - 0010 loads DAC from input registers
// - 0011 writes input and DAC registers
// - 0101 loads four-bit strobe mask
// - Mask bit one makes channel see strobe high
// - Strobe held low disregards mask bits
// - Hardware reset forces zero or midscale
// - Reset blocks updates; cleared value then holds
// - 0110 performs power-on style software reset
// - Power-on reset ignores strobe and hardware reset
// - Power-up level chosen by reset select
package qdc_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int QDC_FRAME_W = 24;
  localparam int QDC_CMD_LSB = 20;
  localparam int QDC_ADDR_LSB = 16;
  localparam int QDC_DATA_W = 16;
  localparam int QDC_CHANNELS = 4;

  typedef logic [QDC_DATA_W-1:0] qdc_code_t;

  // ****************************************
  // Commands
  // ****************************************
  localparam logic [3:0] QDC_CMD_WR_IN = 4'h1;
  localparam logic [3:0] QDC_CMD_UPD = 4'h2;
  localparam logic [3:0] QDC_CMD_WR_UPD = 4'h3;
  localparam logic [3:0] QDC_CMD_PWRDN = 4'h4;
  localparam logic [3:0] QDC_CMD_MASK = 4'h5;
  localparam logic [3:0] QDC_CMD_SWRST = 4'h6;

  // ****************************************
  // Power-down codes and reset values
  // ****************************************
  localparam logic [1:0] QDC_PD_NORMAL = 2'h0;
  localparam logic [1:0] QDC_PD_1K = 2'h1;
  localparam logic [1:0] QDC_PD_100K = 2'h2;
  localparam logic [1:0] QDC_PD_TRISTATE = 2'h3;
  localparam logic [7:0] QDC_PD_RESET = 8'h00;
  localparam logic [3:0] QDC_MASK_RESET = 4'h0;
  localparam qdc_code_t QDC_CODE_ZERO = 16'h0000;
  localparam qdc_code_t QDC_CODE_MID = 16'h8000;

  // ****************************************
  // Synchroniser slots and reset values
  // ****************************************
  localparam int QDC_PIN_FS = 3;
  localparam int QDC_PIN_LD = 2;
  localparam int QDC_PIN_RS = 1;
  localparam int QDC_PIN_SEL = 0;
  localparam logic [3:0] QDC_PIN_RESET = 4'he;

  // ****************************************
  // Timing
  // ****************************************
  localparam int QDC_CLK_PERIOD_PS = 4000;
  localparam int QDC_POR_TIME_NS = 32;
  localparam int QDC_POR_CYCLES =
    (QDC_POR_TIME_NS * 1000 + QDC_CLK_PERIOD_PS - 1) / QDC_CLK_PERIOD_PS;
  localparam logic [7:0] QDC_POR_LOAD = 8'(QDC_POR_CYCLES);

  typedef enum logic [2:0] {
    QDC_ST_POR = 3'h1,
    QDC_ST_RUN = 3'h2,
    QDC_ST_HOLD = 3'h4
  } qdc_state_t;

endpackage

// file: verilog/qdc_frame_if.sv
`timescale 1ns/1ps
interface qdc_frame_if;
  logic [23:0] word;
  modport shifter (output word);
  modport core (input word);
endinterface

// file: verilog/qdc_shifter.sv
`timescale 1ns/1ps
module qdc_shifter
  import qdc_pkg::*;
(
  // Serial link
  input wire logic sclk_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_data_in_i,
  // Word to the core
  qdc_frame_if.shifter frm
);

  // ****************************************
  // Shift register, link clock domain
  // ****************************************
  // No reset here: the clock may stand still, and the core only reads the
  // word after frame select has risen, when no more edges arrive.
  logic [QDC_FRAME_W-1:0] shift_r;

  always_ff @(negedge sclk_i) begin
    if (!frame_sel_n_i) begin
      shift_r <= {shift_r[QDC_FRAME_W-2:0], serial_data_in_i};
    end
  end

  assign frm.word = shift_r;

endmodule

// file: tb/qdc_host.sv
`timescale 1ns/1ps
module qdc_host (
  // Serial link to the device
  output logic sclk_o,
  output logic frame_sel_n_o,
  output logic sdata_o
);
  // ****************************************
  // Frame driver
  // ****************************************
  initial begin
    sclk_o = 1'b1;
    frame_sel_n_o = 1'b1;
    sdata_o = 1'b0;
  end

  // Clock idles high between frames; data flips after the frame so stale bits never look valid
  task automatic send(input logic [23:0] w);
    #5.3 frame_sel_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata_o = w[i];
      #32 sclk_o = 1'b0;
      #32 sclk_o = 1'b1;
    end
    sdata_o = ~w[0];
    #32 frame_sel_n_o = 1'b1;
    #64;
  endtask
endmodule

// file: tb/qdc_top_chk.sv
`timescale 1ns/1ps
module qdc_top_chk
  import qdc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Pins
  input wire logic frame_sel_n_i,
  input wire logic load_strobe_n_i,
  input wire logic hw_reset_n_i,
  // Outputs
  input qdc_code_t [QDC_CHANNELS-1:0] dac_code_o,
  input qdc_code_t [QDC_CHANNELS-1:0] input_code_o,
  input wire logic [7:0] pwrdn_mode_o,
  input wire logic [QDC_CHANNELS-1:0] amp_enable_o,
  input wire logic [QDC_CHANNELS-1:0] pull_1k_o,
  input wire logic [QDC_CHANNELS-1:0] pull_100k_o,
  input wire logic [QDC_CHANNELS-1:0] load_mask_o,
  input wire logic por_busy_o,
  input wire logic hw_hold_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  property p_amp_d;
    amp_enable_o[3] == ($past(pwrdn_mode_o[7:6]) == QDC_PD_NORMAL);
  endproperty
  a_amp_d: assert property (p_amp_d) else $error("channel D amplifier enable wrong");
  property p_pull_a;
    pull_1k_o[0] == ($past(pwrdn_mode_o[1:0]) == QDC_PD_1K)
      && pull_100k_o[0] == ($past(pwrdn_mode_o[1:0]) == QDC_PD_100K);
  endproperty
  a_pull_a: assert property (p_pull_a) else $error("channel A pull select wrong");
  property p_tri_c;
    $past(pwrdn_mode_o[5:4]) == QDC_PD_TRISTATE |-> !amp_enable_o[2] && !pull_1k_o[2] && !pull_100k_o[2];
  endproperty
  a_tri_c: assert property (p_tri_c) else $error("channel C not three-stated");
  property p_por_bound;
    por_busy_o |-> ##[1:12] !por_busy_o;
  endproperty
  a_por_bound: assert property (p_por_bound) else $error("reset sequence too long");
  property p_por_excl;
    por_busy_o |-> !hw_hold_o;
  endproperty
  a_por_excl: assert property (p_por_excl) else $error("hold entered during reset sequence");
  property p_por_clear;
    por_busy_o && $past(por_busy_o) |-> load_mask_o == QDC_MASK_RESET && pwrdn_mode_o == QDC_PD_RESET;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("mask or modes not cleared");
  property p_dac_follow;
    $changed(dac_code_o[0]) |-> dac_code_o[0] == input_code_o[0];
  endproperty
  a_dac_follow: assert property (p_dac_follow) else $error("DAC A loaded with foreign value");
  property p_mask_block;
    (load_mask_o[2] && frame_sel_n_i && hw_reset_n_i && !por_busy_o)[*8] ##1 $fell(load_strobe_n_i)
      |=> $stable(dac_code_o[2])[*6];
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked channel C loaded");
  property p_strobe_load;
    (!load_mask_o[1] && frame_sel_n_i && hw_reset_n_i && !por_busy_o && !hw_hold_o)[*8]
      ##1 $fell(load_strobe_n_i) |-> ##[1:8] dac_code_o[1] == input_code_o[1];
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("strobe did not load channel B");
endmodule

bind qdc_top qdc_top_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .frame_sel_n_i(frame_sel_n_i),
  .load_strobe_n_i(load_strobe_n_i), .hw_reset_n_i(hw_reset_n_i), .dac_code_o(dac_code_o),
  .input_code_o(input_code_o), .pwrdn_mode_o(pwrdn_mode_o), .amp_enable_o(amp_enable_o),
  .pull_1k_o(pull_1k_o), .pull_100k_o(pull_100k_o), .load_mask_o(load_mask_o),
  .por_busy_o(por_busy_o), .hw_hold_o(hw_hold_o));

// file: tb/test_qdc_top.sv
`timescale 1ns/1ps
module test_qdc_top;
  import qdc_pkg::*;
  typedef struct packed {logic [63:0] dac; logic [63:0] inp; logic [7:0] pd; logic [3:0] msk;} qdc_note_t;
  logic mclk_i = 0, sys_rst_i = 1, ld_n = 1, hrst_n = 1, sel = 1;
  wire sclk, fs_n, sdi;
  qdc_code_t [3:0] dac_code, in_code, e_in, e_dac;
  logic [7:0] pd, e_pd;
  logic [3:0] msk, e_msk;
  qdc_note_t notes[$];
  int bad_count = 0, n_compared = 0;
  event chk_ev;

  initial forever #2 mclk_i = ~mclk_i;

  qdc_host u_qdc_host (.sclk_o(sclk), .frame_sel_n_o(fs_n), .sdata_o(sdi));
  qdc_top u_qdc_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .frame_sel_n_i(fs_n),
    .serial_data_in_i(sdi), .load_strobe_n_i(ld_n), .hw_reset_n_i(hrst_n), .reset_level_select_i(sel),
    .dac_code_o(dac_code), .input_code_o(in_code), .pwrdn_mode_o(pd), .amp_enable_o(), .pull_1k_o(),
    .pull_100k_o(), .load_mask_o(msk), .por_busy_o(), .hw_hold_o());

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic note();
    notes.push_back({e_dac, e_in, e_pd, e_msk});
    ->chk_ev;
  endtask

  initial forever begin
    qdc_note_t n;
    @chk_ev;
    #1;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check("dac", dac_code, n.dac);
      check("input", in_code, n.inp);
      check("pwrdn", 64'(pd), 64'(n.pd));
      check("mask", 64'(msk), 64'(n.msk));
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic wr(logic [3:0] c, logic [3:0] a, logic [15:0] d);
    u_qdc_host.send({c, a, d});
    repeat (20) @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      if (a[i] && c == QDC_CMD_WR_IN) begin
        e_in[i] = d;
        if (!ld_n) e_dac[i] = d;
      end
      if (a[i] && c == QDC_CMD_UPD) e_dac[i] = e_in[i];
      if (a[i] && c == QDC_CMD_WR_UPD) begin
        e_in[i] = d;
        e_dac[i] = d;
      end
    end
    if (c == QDC_CMD_PWRDN) e_pd = d[7:0];
    if (c == QDC_CMD_MASK) e_msk = d[3:0];
    if (c == QDC_CMD_SWRST) begin
      e_in = {4{sel ? QDC_CODE_MID : QDC_CODE_ZERO}};
      e_dac = e_in;
      e_pd = QDC_PD_RESET;
      e_msk = QDC_MASK_RESET;
    end
  endtask

  // Strobe is only pulsed with the frame select idle high
  task automatic pulse();
    ld_n <= 1'b0;
    repeat (8) @(posedge mclk_i);
    ld_n <= 1'b1;
    repeat (8) @(posedge mclk_i);
    for (int i = 0; i < 4; i++) if (!e_msk[i]) e_dac[i] = e_in[i];
  endtask

  initial begin
    void'($urandom(90));
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    e_in = {4{QDC_CODE_MID}};
    e_dac = e_in;
    e_pd = QDC_PD_RESET;
    e_msk = QDC_MASK_RESET;
    note();
    wr(QDC_CMD_WR_IN, 4'h5, 16'($urandom)); note();
    pulse(); note();
    wr(QDC_CMD_MASK, 4'ha, 16'hff05); note();
    wr(QDC_CMD_WR_IN, 4'hf, 16'($urandom)); pulse(); note();
    ld_n <= 1'b0;
    wr(QDC_CMD_WR_IN, 4'hf, 16'($urandom)); note();
    ld_n <= 1'b1;
    wr(QDC_CMD_WR_IN, 4'hf, 16'($urandom));
    wr(QDC_CMD_UPD, 4'h3, 16'($urandom)); note();
    wr(QDC_CMD_WR_UPD, 4'h8, 16'($urandom)); note();
    // Byte 0x39 sets all four modes at once across the channels
    wr(QDC_CMD_PWRDN, 4'h7, 16'ha539); note();
    wr(QDC_CMD_WR_UPD, 4'h1, 16'($urandom)); note();
    sel <= 1'b0;
    hrst_n <= 1'b0;
    repeat (10) @(posedge mclk_i);
    e_in = {4{QDC_CODE_ZERO}};
    e_dac = e_in;
    e_pd = QDC_PD_RESET;
    e_msk = QDC_MASK_RESET;
    u_qdc_host.send({QDC_CMD_WR_UPD, 4'hf, 16'h1234});
    repeat (20) @(posedge mclk_i); note();
    hrst_n <= 1'b1;
    repeat (20) @(posedge mclk_i); note();
    sel <= 1'b1;
    wr(QDC_CMD_MASK, 4'h0, 16'h000f);
    wr(QDC_CMD_PWRDN, 4'h0, 16'h00ff);
    wr(QDC_CMD_SWRST, 4'h0, 16'h0000); note();
    repeat (10) @(posedge mclk_i);
    stop_test();
  end

  initial begin
    #100us;
    bad_count++;
    stop_test();
  end
endmodule
